/* hw/dacro_device.sv */
// module: converter end, calibration, pipeline and DDR output bus
// Functional notes
// - code appears seven and half cycles after sampling
// - both cores calibrate before output is valid
// - supply monitor releases recal line, starting calibration
// - calibration starts on recal line rising edge
// - over-range forced high from low until done
// - after calibration over-range reports real overflow
// - output strobe held low while recal low
// - strobe resumes at next sample edge after release
// - calibration lasts about 300 ms at full rate
// - host pulses recal low at least one cycle
// - host keeps clock steady, no serial traffic
// - serial data line high at power-up
// - recal line must start low at power-up
// - serial port may request recalibration later
// - twelve bits, msb bit 11, range, strobe
// - host drives select low to address device
// - channel A on strobe low, B on high
`timescale 1ns/1ns
module dacro_device #(
   parameter int unsigned CAL_CYCLES = dacro_pkg::CAL_CYCLES,
   parameter int unsigned POR_CYCLES = 8
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // link
   dacro_if.device          link,
   // user side: sample sources for the two cores
   input  wire logic [11:0] sample_a,
   input  wire logic [11:0] sample_b,
   input  wire logic        over_a,
   input  wire logic        over_b,
   // user side: status
   output      logic        cal_busy,
   output      logic        cal_fault
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers for pins
   logic [1:0] clk_sync;
   logic [1:0] rst_sync;
   logic [1:0] sdo_sync;
   logic [1:0] csn_sync;
   logic [1:0] req_sync;
   logic       clk_q;
   logic       recal_q;
   logic       req_q;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         clk_sync <= '0;
         rst_sync <= '0;
         sdo_sync <= 2'h3;
         csn_sync <= 2'h3;
         req_sync <= '0;
         clk_q    <= 1'b0;
         recal_q  <= 1'b0;
         req_q    <= 1'b0;
      end
      else
      begin
         clk_sync <= {clk_sync[0], link.sample_clock_true};
         rst_sync <= {rst_sync[0], link.recal_reset_n};
         sdo_sync <= {sdo_sync[0], link.serial_data_high};
         csn_sync <= {csn_sync[0], link.serial_select_n};
         req_sync <= {req_sync[0], link.serial_recal_req};
         clk_q    <= clk_sync[1];
         recal_q  <= rst_sync[1];
         req_q    <= req_sync[1];
      end
   end

   wire clk_rise  = clk_sync[1] && !clk_q;
   wire clk_edge  = clk_sync[1] != clk_q;
   wire recal_low = !rst_sync[1];
   wire recal_up  = rst_sync[1] && !recal_q;
   // serial recal only while selected, after the first calibration
   wire spi_recal = req_sync[1] && !req_q && !csn_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // power-on monitor holds the line low, then lets the pull-up act
   // registered so the line driver comes straight from a flop
   logic [3:0] por_cnt;
   logic       por_hold;
   wire        por_done = (por_cnt == 4'(POR_CYCLES));
   wire        por_last = (por_cnt == 4'(POR_CYCLES - 1));
   assign link.recal_reset_n_dev_oe = por_hold;

   ////////////////////////////////////////////////////////////////////////
   // calibration state machine
   dacro_pkg::dacro_state_t state;
   dacro_pkg::dacro_state_t next_state;
   logic [dacro_pkg::CAL_CNT_W-1:0] cal_cnt;
   wire cal_done = (cal_cnt == dacro_pkg::CAL_CNT_W'(CAL_CYCLES - 1));

   always_comb
   begin
      next_state = state;
      unique case (state)
         dacro_pkg::DACRO_POR: if (por_done && recal_up) next_state = dacro_pkg::DACRO_CAL;
         dacro_pkg::DACRO_CAL:
            if (recal_low) next_state = dacro_pkg::DACRO_POR;
            else if (clk_rise && cal_done) next_state = dacro_pkg::DACRO_RUN;
         dacro_pkg::DACRO_RUN:
            if (recal_low) next_state = dacro_pkg::DACRO_POR;
            else if (spi_recal) next_state = dacro_pkg::DACRO_CAL;
         default: next_state = dacro_pkg::DACRO_POR;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state     <= dacro_pkg::DACRO_POR;
         por_cnt   <= '0;
         por_hold  <= 1'b1;
         cal_cnt   <= '0;
         cal_fault <= 1'b0;
         cal_busy  <= 1'b1;
      end
      else
      begin
         state    <= next_state;
         por_hold <= !por_done && !por_last;
         cal_busy <= (next_state != dacro_pkg::DACRO_RUN);
         if (!por_done)
         begin
            por_cnt <= por_cnt + 4'h1;
         end
         // both cores share one counter; they calibrate side by side
         if (state != dacro_pkg::DACRO_CAL)
         begin
            cal_cnt <= '0;
         end
         else if (clk_rise)
         begin
            cal_cnt <= cal_cnt + 1'b1;
         end
         // a low serial data line at the start spoils the calibration
         if (recal_up)
         begin
            cal_fault <= !sdo_sync[1];
         end
      end
   end

   wire running     = (state == dacro_pkg::DACRO_RUN);
   // the line itself forces the flag, so it does not wait for the state
   wire force_range = !running || recal_low;

   ////////////////////////////////////////////////////////////////////////
   // pipeline, counted in half cycles so the half-cycle latency is exact
   logic [24:0] pipe [dacro_pkg::LATENCY_HALVES];
   genvar g;
   generate
      for (g = 0; g < dacro_pkg::LATENCY_HALVES; g++)
      begin : g_pipe
         if (g == 0)
         begin : g_head
            always_ff @(posedge sys_clk)
            begin
               if (!rst_n)
               begin
                  pipe[g] <= '0;
               end
               else if (clk_edge)
               begin
                  pipe[g] <= {over_a | over_b, sample_b, sample_a};
               end
            end
         end
         else
         begin : g_tail
            always_ff @(posedge sys_clk)
            begin
               if (!rst_n)
               begin
                  pipe[g] <= '0;
               end
               else if (clk_edge)
               begin
                  pipe[g] <= pipe[g-1];
               end
            end
         end
      end
   endgenerate

   wire [24:0] pipe_out = pipe[dacro_pkg::LATENCY_HALVES-1];

   ////////////////////////////////////////////////////////////////////////
   // DDR output: strobe follows sample clock, A low phase, B high phase
   logic strobe;
   wire  next_strobe = recal_low ? 1'b0 : (clk_edge ? clk_sync[1] : strobe);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         strobe                    <= 1'b0;
         link.data_code            <= dacro_pkg::CODE_RESET;
         link.over_range_flag_true <= 1'b1;
      end
      else
      begin
         strobe <= next_strobe;
         if (clk_edge)
         begin
            link.data_code <= clk_sync[1] ? pipe_out[23:12] : pipe_out[11:0];
         end
         // forced during recal low and calibration, true range otherwise
         link.over_range_flag_true <= force_range ? 1'b1 : pipe_out[24];
      end
   end

   assign link.data_strobe_out_true = strobe;
endmodule // dacro_device

/* hw/dacro_fifo.sv */
// module: small valid/ready word FIFO
`timescale 1ns/1ns
module dacro_fifo #(
   parameter int unsigned WIDTH = 13,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire              empty = (wr_ptr == rd_ptr);
   wire              push  = in_valid && !full;
   wire              pop   = out_valid && out_ready;

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // dacro_fifo

/* hw/dacro_host.sv */
// module: data capture receiver, clock source and recal driver
`timescale 1ns/1ns
module dacro_host (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // link
   dacro_if.host            link,
   // user side: control
   input  wire logic        recal_req,
   input  wire logic        spi_recal_req,
   // user side: captured pairs
   output      logic        pair_valid,
   input  wire logic        pair_ready,
   output      logic [11:0] code_a,
   output      logic [11:0] code_b,
   output      logic        over_range,
   output      logic        cal_busy
);
   ////////////////////////////////////////////////////////////////////////
   // sample clock divider, steady through calibration
   logic [dacro_pkg::LINK_DIV_W-1:0] div_cnt;
   logic                             sclk;
   wire div_wrap = (div_cnt == dacro_pkg::LINK_DIV_W'(dacro_pkg::LINK_HALF_DIV - 1));

   // recal pulse: one full sample period low
   logic [3:0] pulse_cnt;
   wire        pulse_done = (pulse_cnt == 4'(2 * dacro_pkg::LINK_HALF_DIV * dacro_pkg::RECAL_PULSE_CYC));

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         div_cnt   <= '0;
         sclk      <= 1'b0;
         pulse_cnt <= 4'hf;
      end
      else
      begin
         div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
         if (div_wrap)
         begin
            sclk <= !sclk;
         end
         if (recal_req && pulse_done)
         begin
            pulse_cnt <= '0;
         end
         else if (!pulse_done)
         begin
            pulse_cnt <= pulse_cnt + 4'h1;
         end
      end
   end

   assign link.sample_clock_true     = sclk;
   assign link.recal_reset_n_host_oe = !pulse_done;
   assign link.serial_data_high      = 1'b1;
   // select low only while the serial recal request is issued
   assign link.serial_select_n       = !spi_recal_req;
   assign link.serial_recal_req      = spi_recal_req;

   ////////////////////////////////////////////////////////////////////////
   // capture: synchronise strobe, take A on falling, B on rising
   logic [1:0]  stb_sync;
   logic        stb_q;
   logic [1:0]  or_sync;
   logic [11:0] hold_a;
   logic        fifo_ready;
   wire         stb_fall = !stb_sync[1] && stb_q;
   wire         stb_rise = stb_sync[1] && !stb_q;
   // the bus is stable mid-phase, sample the strobe-aligned data
   wire [24:0]  word = {or_sync[1], link.data_code, hold_a};

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stb_sync <= '0;
         stb_q    <= 1'b0;
         or_sync  <= 2'h3;
         hold_a   <= '0;
      end
      else
      begin
         stb_sync <= {stb_sync[0], link.data_strobe_out_true};
         stb_q    <= stb_sync[1];
         or_sync  <= {or_sync[0], link.over_range_flag_true};
         if (stb_fall)
         begin
            hold_a <= link.data_code;
         end
      end
   end

   logic        out_valid;
   logic [24:0] out_data;
   dacro_fifo #(.WIDTH(25), .DEPTH(dacro_pkg::FIFO_DEPTH)) dacro_fifo_inst (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (stb_rise && fifo_ready),
      .in_ready  (fifo_ready),
      .in_data   (word),
      .out_valid (out_valid),
      .out_ready (pair_ready || !pair_valid),
      .out_data  (out_data)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pair_valid <= 1'b0;
         code_a     <= '0;
         code_b     <= '0;
         over_range <= 1'b1;
         cal_busy   <= 1'b1;
      end
      else
      begin
         if (pair_ready || !pair_valid)
         begin
            pair_valid <= out_valid;
            if (out_valid)
            begin
               {over_range, code_b, code_a} <= out_data;
            end
         end
         cal_busy <= or_sync[1] && !stb_sync[1];
      end
   end
endmodule // dacro_host

/* hw/dacro_if.sv */
// interface: link between converter control and data capture receiver
`timescale 1ns/1ns
interface dacro_if;
   // sample clock driven by host
   logic        sample_clock_true;
   // open drain recal line, pulled up when nobody drives low
   logic        recal_reset_n_dev_oe;
   logic        recal_reset_n_host_oe;
   wire         recal_reset_n = ~(recal_reset_n_dev_oe | recal_reset_n_host_oe);
   // serial data out level, must be high at power-up
   logic        serial_data_high;
   logic        serial_select_n;
   logic        serial_recal_req;
   // output bus
   logic [11:0] data_code;
   logic        over_range_flag_true;
   logic        data_strobe_out_true;

   modport device (
      input  sample_clock_true,
      input  recal_reset_n,
      output recal_reset_n_dev_oe,
      input  serial_data_high,
      input  serial_select_n,
      input  serial_recal_req,
      output data_code,
      output over_range_flag_true,
      output data_strobe_out_true
   );
   modport host (
      output sample_clock_true,
      input  recal_reset_n,
      output recal_reset_n_host_oe,
      output serial_data_high,
      output serial_select_n,
      output serial_recal_req,
      input  data_code,
      input  over_range_flag_true,
      input  data_strobe_out_true
   );
endinterface

/* hw/dacro_pkg.sv */
// package: shared constants for the dual converter control link
package dacro_pkg;
   localparam int unsigned DATA_W          = 12;
   localparam int unsigned FIFO_DEPTH      = 16;
   localparam int unsigned SYS_CLK_MHZ     = 50;
   // pipeline latency in half sample periods (seven and a half cycles)
   localparam int unsigned LATENCY_HALVES  = 15;
   // calibration time at the top sample rate, in milliseconds
   localparam int unsigned CAL_TIME_MS     = 300;
   localparam int unsigned SAMPLE_RATE_MSPS = 250;
   // calibration length counted in sample clock cycles
   localparam int unsigned CAL_CYCLES      = CAL_TIME_MS * 1000 * SAMPLE_RATE_MSPS;
   localparam int unsigned CAL_CNT_W       = 27;
   // host link clock divider: half period in sys_clk cycles (160 ns period)
   localparam int unsigned LINK_HALF_DIV   = 4;
   localparam int unsigned LINK_DIV_W      = 3;
   // least recal pulse, in sample cycles, held by the host
   localparam int unsigned RECAL_PULSE_CYC = 1;
   localparam logic [11:0] CODE_RESET      = 12'h000;
   typedef enum logic [1:0] {
      DACRO_POR  = 2'b00,
      DACRO_CAL  = 2'b01,
      DACRO_RUN  = 2'b11
   } dacro_state_t;
endpackage

/* verification/dacro_properties.sv */
// checker: link timing properties between converter end and receiver
`timescale 1ns/1ns
module dacro_properties #(
   parameter int unsigned CAL_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // link
   input wire logic sample_clock_true,
   input wire logic recal_reset_n,
   input wire logic recal_reset_n_dev_oe,
   input wire logic recal_reset_n_host_oe,
   input wire logic over_range_flag_true,
   input wire logic data_strobe_out_true
);
   logic [15:0] smp_cnt;
   logic        smp_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // sample rises since the line went high; saturates so serial recal never wraps
   always_ff @(posedge sys_clk)
   begin
      smp_q <= sample_clock_true;
      if (!rst_n || !recal_reset_n)
         smp_cnt <= 16'h0000;
      else if (sample_clock_true && !smp_q && smp_cnt != 16'hffff)
         smp_cnt <= smp_cnt + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_range_on_low: assert property
      ($fell(recal_reset_n) |-> ##[0:3] over_range_flag_true)
      else $error("over-range not raised after recal low");
   a_range_after_rise: assert property
      ($rose(recal_reset_n) |-> over_range_flag_true[*8])
      else $error("over-range dropped as calibration began");
   // margin of two sample rises covers the synchroniser in the device
   a_range_held_cal: assert property
      ((recal_reset_n && smp_cnt < CAL_CYCLES - 2) |-> over_range_flag_true)
      else $error("over-range dropped before calibration end");
   a_strobe_held_low: assert property
      ((!recal_reset_n)[*6] |-> !data_strobe_out_true)
      else $error("strobe not held low during recal");
   a_strobe_restart: assert property
      ($rose(recal_reset_n) |-> ##[1:30] data_strobe_out_true)
      else $error("strobe did not resume after recal");
   a_strobe_spacing: assert property
      ($rose(data_strobe_out_true) |=> (!$rose(data_strobe_out_true))[*7])
      else $error("strobe faster than sample clock");
   a_host_pulse_len: assert property
      ($rose(recal_reset_n_host_oe) |-> recal_reset_n_host_oe[*8] ##1 !recal_reset_n_host_oe)
      else $error("host recal pulse length wrong");
   a_por_pulse_len: assert property
      ($rose(rst_n) |-> recal_reset_n_dev_oe[*8] ##1 !recal_reset_n_dev_oe)
      else $error("power-on recal pulse length wrong");
   c_recal: cover property ($rose(recal_reset_n_host_oe));
   c_cal_done: cover property ($fell(over_range_flag_true));
   c_strobe: cover property ($rose(data_strobe_out_true));
endmodule // dacro_properties

/* verification/dual_adc_calibration_reset_output_bench.sv */
// testbench: converter end and receiver joined over the link
`timescale 1ns/1ns
module dual_adc_calibration_reset_output_bench;
   localparam int unsigned CAL = 20;
   logic        sys_clk;
   logic        rst_n;
   logic [11:0] sample_a;
   logic [11:0] sample_b;
   logic        over_a;
   logic        over_b;
   logic        recal_req;
   logic        spi_recal_req;
   logic        pair_ready;
   logic        pair_valid;
   logic [11:0] code_a;
   logic [11:0] code_b;
   logic        over_range;
   logic        dev_busy;
   logic        dev_fault;
   logic        host_busy;
   logic        bad_fault;
   int          n_fail;
   int          checks;
   dacro_if link ();
   dacro_if bad_link ();
   dacro_device #(.CAL_CYCLES(CAL)) dacro_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .link(link), .sample_a(sample_a), .sample_b(sample_b), .over_a(over_a),
      .over_b(over_b), .cal_busy(dev_busy), .cal_fault(dev_fault));
   dacro_host dacro_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
      .recal_req(recal_req), .spi_recal_req(spi_recal_req), .pair_valid(pair_valid),
      .pair_ready(pair_ready), .code_a(code_a), .code_b(code_b), .over_range(over_range),
      .cal_busy(host_busy));
   // second end whose serial data line is held low at power-up
   dacro_device #(.CAL_CYCLES(CAL)) dacro_device_fault_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .link(bad_link), .sample_a(sample_a), .sample_b(sample_b),
      .over_a(over_a), .over_b(over_b), .cal_busy(), .cal_fault(bad_fault));
   assign bad_link.sample_clock_true = link.sample_clock_true;
   dacro_properties #(.CAL_CYCLES(CAL)) dacro_properties_inst (.sys_clk(sys_clk),
      .rst_n(rst_n), .sample_clock_true(link.sample_clock_true),
      .recal_reset_n(link.recal_reset_n), .recal_reset_n_dev_oe(link.recal_reset_n_dev_oe),
      .recal_reset_n_host_oe(link.recal_reset_n_host_oe),
      .over_range_flag_true(link.over_range_flag_true),
      .data_strobe_out_true(link.data_strobe_out_true));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic final_report();
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic probe(input int k);
      case (k)
         0: probe = (dev_busy === 1'b0);
         1: probe = (dev_busy === 1'b1);
         2: probe = (pair_valid === 1'b1);
         3: probe = (link.sample_clock_true === 1'b1);
         default: probe = (link.sample_clock_true === 1'b0);
      endcase
   endfunction
   task automatic wait_for(input int k, input int lim);
      int n;
      n = 0;
      while (!probe(k) && n < lim)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (!probe(k))
      begin
         n_fail++;
         $display("ERROR wait_%0d expected 1 seen 0", k);
         final_report();
      end
   endtask
   task automatic pulse_recal();
      recal_req = 1'b1;
      @(negedge sys_clk);
      recal_req = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_startup();
      repeat (2) @(negedge sys_clk);
      chk("line_low", 12'h000, 12'(link.recal_reset_n));
      chk("range_cal", 12'h001, 12'(link.over_range_flag_true));
      chk("busy_cal", 12'h001, 12'(dev_busy));
      chk("host_busy_cal", 12'h001, 12'(host_busy));
      wait_for(0, 600);
      repeat (4) @(negedge sys_clk);
      chk("range_done", 12'h000, 12'(link.over_range_flag_true));
      chk("fault_ok", 12'h000, 12'(dev_fault));
      chk("fault_sdo", 12'h001, 12'(bad_fault));
      chk("host_busy_done", 12'h000, 12'(host_busy));
   endtask
   task automatic t_pairs();
      sample_a = 12'h5a3;
      sample_b = 12'ha5c;
      repeat (160) @(negedge sys_clk);
      wait_for(2, 20);
      chk("code_a", 12'h5a3, code_a);
      chk("code_b", 12'ha5c, code_b);
      chk("range_a", 12'h000, 12'(over_range));
      over_b = 1'b1;
      repeat (160) @(negedge sys_clk);
      chk("range_b", 12'h001, 12'(link.over_range_flag_true));
      over_b = 1'b0;
      repeat (160) @(negedge sys_clk);
   endtask
   task automatic t_latency();
      int   n;
      logic prev;
      wait_for(3, 20);
      wait_for(4, 20);
      sample_a = 12'h0f1;
      n = 0;
      prev = 1'b0;
      for (int i = 0; i < 200; i++)
      begin
         if (link.data_code === 12'h0f1 && link.data_strobe_out_true === 1'b0)
            break;
         @(negedge sys_clk);
         if (link.sample_clock_true === 1'b1 && prev === 1'b0)
            n++;
         prev = link.sample_clock_true;
      end
      chk("latency", 12'h001, 12'(n >= 8 && n <= 9));
      sample_a = 12'h5a3;
   endtask
   // second pass holds an over-range input so completion stays hidden
   task automatic t_recal(input logic ovr);
      over_a = ovr;
      pulse_recal();
      repeat (3) @(negedge sys_clk);
      chk("recal_low", 12'h000, 12'(link.recal_reset_n));
      repeat (3) @(negedge sys_clk);
      chk("strobe_low", 12'h000, 12'(link.data_strobe_out_true));
      chk("range_recal", 12'h001, 12'(link.over_range_flag_true));
      wait_for(1, 40);
      wait_for(0, 600);
      repeat (160) @(negedge sys_clk);
      chk("range_end", 12'(ovr), 12'(link.over_range_flag_true));
      over_a = 1'b0;
      repeat (160) @(negedge sys_clk);
   endtask
   task automatic t_spi();
      spi_recal_req = 1'b1;
      wait_for(1, 80);
      spi_recal_req = 1'b0;
      wait_for(0, 600);
   endtask
   // receiver stalls past the buffer depth, then drains in one burst
   task automatic t_fifo();
      int n;
      pair_ready = 1'b0;
      repeat (400) @(negedge sys_clk);
      chk("stall_valid", 12'h001, 12'(pair_valid));
      pair_ready = 1'b1;
      n = 0;
      while (pair_valid === 1'b1 && n < 40)
      begin
         chk("fifo_b", 12'ha5c, code_b);
         n++;
         @(negedge sys_clk);
      end
      chk("fifo_count", 12'h001, 12'(n >= 16 && n <= 20));
   endtask
   initial
   begin
      n_fail = 0;
      checks = 0;
      rst_n = 1'b0;
      sample_a = 12'h000;
      sample_b = 12'h000;
      over_a = 1'b0;
      over_b = 1'b0;
      recal_req = 1'b0;
      spi_recal_req = 1'b0;
      pair_ready = 1'b1;
      bad_link.recal_reset_n_host_oe = 1'b0;
      bad_link.serial_data_high = 1'b0;
      bad_link.serial_select_n = 1'b1;
      bad_link.serial_recal_req = 1'b0;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      t_startup();
      t_pairs();
      t_latency();
      t_recal(1'b0);
      t_recal(1'b1);
      t_spi();
      t_fifo();
      final_report();
   end
endmodule // dual_adc_calibration_reset_output_bench
